// [hdl/pesd_map.vh]
// Register map, field positions, reset values and timing counts
`ifndef PESD_MAP_VH
`define PESD_MAP_VH

// Register byte offsets
`define PESD_OFS_CONTROL 16'h0004
`define PESD_OFS_RUN_STATE 16'h0008
`define PESD_OFS_GLOBAL_EN 16'h0010
`define PESD_OFS_GLOBAL_STATE 16'h0014
`define PESD_OFS_SUB_EN_BASE 16'h0100
`define PESD_OFS_SUB_STATE_BASE 16'h0140

// Peripheral control fields
`define PESD_CTL_FREE_BIT 0
`define PESD_CTL_SOFT_BIT 1
`define PESD_CTL_PEREN_BIT 2
`define PESD_CTL_FREE_RST 1'h1
`define PESD_CTL_SOFT_RST 1'h0
`define PESD_CTL_PEREN_RST 1'h0

// Run state fields
`define PESD_RUN_HALTED_BIT 0
`define PESD_RUN_STOPREQ_BIT 1

// Subblock count: block 0 is the register unit, 1..8 as mapped
`define PESD_NUM_SUB 9

// Clock cycles the clock keeps running after a subblock enters reset
`define PESD_DRAIN_CYCLES 32

`endif

// [hdl/pesd_blkseq.v]
// Reset and clock-gate sequencer for one subblock
`timescale 1ns/1ns
module pesd_blkseq #(
  parameter DRAIN_CYCLES = 32,
  parameter CNT_W = 6
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Request: high keeps the subblock running
  input wire enable,
  // Subblock controls and state
  output reg sub_reset,
  output reg clk_run,
  output reg state_on
);
  localparam ST_OFF = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DRAIN = 2'h2;
  localparam integer LAST_I = DRAIN_CYCLES - 1;
  localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];

  reg [1:0] state;
  reg [CNT_W-1:0] cnt;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_OFF;
      cnt <= {CNT_W{1'b0}};
      sub_reset <= 1'b1;
      clk_run <= 1'b0;
      state_on <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          state_on <= 1'b0;
          if (enable) begin
            // Release reset and clock together
            state <= ST_RUN; // [R4] [R18]
            sub_reset <= 1'b0;
            clk_run <= 1'b1;
          end
        end
        ST_RUN: begin
          state_on <= 1'b1; // [R4] [R5]
          if (!enable) begin
            state <= ST_DRAIN; // [R18]
            sub_reset <= 1'b1;
            cnt <= {CNT_W{1'b0}};
          end
        end
        ST_DRAIN: begin
          if (enable) begin
            // Abandon the drain, clock never stopped
            state <= ST_RUN; // [R20]
            sub_reset <= 1'b0;
          end else if (cnt == LAST) begin
            state <= ST_OFF; // [R2]
            clk_run <= 1'b0;
            state_on <= 1'b0; // [R3] [R5]
          end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1}; // [R2]
          end
        end
        default: begin
          state <= ST_OFF;
          sub_reset <= 1'b1;
          clk_run <= 1'b0;
          state_on <= 1'b0;
        end
      endcase
    end
  end
endmodule

// [hdl/pesd_halt.v]
// Emulation halt control: free run and graceful stop gating
`timescale 1ns/1ns
module pesd_halt (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Control
  input wire suspend,
  input wire free_run,
  input wire peren,
  // Activity from the subblocks
  input wire rx_pkt_busy,
  input wire tx_pkt_busy,
  input wire dma_pkt_busy,
  input wire rx_buf_full,
  input wire new_pkt_event,
  input wire done_event,
  // Gating outputs
  output reg stop_req,
  output reg halted,
  output reg txn_allow,
  output reg dma_new_pkt_allow,
  output reg tx_new_allow,
  output reg rx_retry,
  output reg cpu_event
);
  // Hard stop is unsupported, so both soft settings give a graceful stop
  wire next_stop = suspend & ~free_run; // [R9] [R10]

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_req <= 1'b0;
      halted <= 1'b0;
      txn_allow <= 1'b0;
      dma_new_pkt_allow <= 1'b0;
      tx_new_allow <= 1'b0;
      rx_retry <= 1'b0;
      cpu_event <= 1'b0;
    end else begin
      stop_req <= next_stop;
      // Halt point only once no packet is moving on either side
      halted <= next_stop & ~rx_pkt_busy & ~tx_pkt_busy
        & ~dma_pkt_busy; // [R11]
      txn_allow <= peren & ~next_stop; // [R7]
      // A packet already under way keeps its DMA requests flowing
      dma_new_pkt_allow <= peren & (~next_stop | dma_pkt_busy); // [R12]
      tx_new_allow <= peren & ~next_stop; // [R16]
      rx_retry <= next_stop & rx_buf_full; // [R15]
      cpu_event <= done_event | (new_pkt_event & ~next_stop); // [R14]
    end
  end
endmodule

// [hdl/pesd_top.v]
// Peripheral enable, shutdown sequencing and emulation halt control
// Contract
// R1: Global enable ORs into reset of every subblock.
// R2: Disabled subblock keeps clock 32 cycles, then clock is gated.
// R3: Status bits read 0 once shutdown and gating finish.
// R4: Enabling releases reset, restarts clock; status reads 1 afterwards.
// R5: Block status is 0 when reset and stopped, 1 when clocking.
// R6: Software ends outgoing packets before clearing global enable.
// R7: Peripheral enable bit 2 at 0 blocks new logical transactions.
// R8: Software waits for DMA to finish before clearing global enable.
// R9: Free-run bit set makes debug suspend ignored.
// R10: Free-run 0 selects by bit 1; graceful only, hard unsupported.
// R11: Graceful halt only after in-progress packets complete.
// R12: DMA finishes current packet requests, none for next packet.
// R13: Register accesses served normally during graceful stop.
// R14: No new events for new packets; completions may still signal.
// R15: Inbound accepts while buffers remain, then physical retries.
// R16: Outbound starts nothing new, finishes buffered packets.
// R17: While disabled, register writes ignored and reads return zero.
// R18: Block enable 0 holds reset and gates clock; 1 enables.
// R19: Blocks 1..8 are load/store, memory access, tx, rx, ports 0..3.
// R20: Re-enable during shutdown count keeps clock and releases reset.
`timescale 1ns/1ns
`include "pesd_map.vh"
module pesd_top #(
  parameter NUM_SUB = `PESD_NUM_SUB,
  parameter DRAIN_CYCLES = `PESD_DRAIN_CYCLES
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg wb_ack_o,
  output reg [31:0] wb_dat_o,
  // CPU debug suspend
  input wire debug_suspend_request,
  // Subblock activity
  input wire rx_pkt_busy,
  input wire tx_pkt_busy,
  input wire dma_pkt_busy,
  input wire rx_buf_full,
  input wire new_pkt_event,
  input wire done_event,
  // Subblock resets and clock enables, bit n is block n
  output wire [NUM_SUB-1:0] subblock_reset,
  output wire [NUM_SUB-1:0] subblock_clk_en,
  // Logical layer, DMA and link gating
  output wire txn_allow,
  output wire dma_new_pkt_allow,
  output wire tx_new_allow,
  output wire rx_retry,
  output wire cpu_event,
  output wire halted
);
  // Registers
  reg peripheral_global_enable;
  reg [NUM_SUB-1:0] subblock_enable;
  reg ctl_free;
  reg ctl_soft;
  reg ctl_peren;
  reg susp_meta;
  reg susp_sync;

  wire global_enable_state;
  wire [NUM_SUB-1:0] subblock_enable_state;
  wire [NUM_SUB-1:0] seq_reset;
  wire stop_req;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  // Ends kept at full integer width so a large NUM_SUB cannot wrap
  wire [31:0] sub_en_end = `PESD_OFS_SUB_EN_BASE + (NUM_SUB * 4);
  wire [31:0] sub_st_end = `PESD_OFS_SUB_STATE_BASE + (NUM_SUB * 4);
  wire hit_sub_en = (wb_adr_i >= `PESD_OFS_SUB_EN_BASE)
    && ({16'h0000, wb_adr_i} < sub_en_end) && (wb_adr_i[1:0] == 2'h0);
  wire hit_sub_st = (wb_adr_i >= `PESD_OFS_SUB_STATE_BASE)
    && ({16'h0000, wb_adr_i} < sub_st_end) && (wb_adr_i[1:0] == 2'h0);
  wire [15:0] en_off = wb_adr_i - `PESD_OFS_SUB_EN_BASE;
  wire [15:0] st_off = wb_adr_i - `PESD_OFS_SUB_STATE_BASE;
  wire [3:0] en_idx = en_off[5:2];
  wire [3:0] st_idx = st_off[5:2];

  // Until the peripheral is up only the global enable is reachable;
  // the control registers also need the register unit running.
  wire live_sub = global_enable_state; // [R17]
  wire live_ctl = global_enable_state
    & subblock_enable_state[0]; // [R17]

  // Debug suspend crosses from the CPU's domain
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      susp_meta <= 1'b0;
      susp_sync <= 1'b0;
    end else begin
      susp_meta <= debug_suspend_request;
      susp_sync <= susp_meta;
    end
  end

  // Register writes, taken on the request edge
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      peripheral_global_enable <= 1'b0;
      subblock_enable <= {NUM_SUB{1'b0}};
      ctl_free <= `PESD_CTL_FREE_RST;
      ctl_soft <= `PESD_CTL_SOFT_RST;
      ctl_peren <= `PESD_CTL_PEREN_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == `PESD_OFS_GLOBAL_EN) begin
        peripheral_global_enable <= wb_dat_i[0];
      end
      if (hit_sub_en && live_sub) begin
        subblock_enable[en_idx] <= wb_dat_i[0]; // [R18] [R19]
      end
      // Served the same way whether halted or not
      if ((wb_adr_i == `PESD_OFS_CONTROL) && live_ctl) begin // [R13]
        ctl_free <= wb_dat_i[`PESD_CTL_FREE_BIT]; // [R9]
        ctl_soft <= wb_dat_i[`PESD_CTL_SOFT_BIT]; // [R10]
        ctl_peren <= wb_dat_i[`PESD_CTL_PEREN_BIT]; // [R7]
      end
    end
  end

  // Read mux
  reg [31:0] next_dat;
  always @* begin
    next_dat = 32'h00000000;
    if (wb_adr_i == `PESD_OFS_GLOBAL_EN) begin
      next_dat[0] = peripheral_global_enable;
    end else if (wb_adr_i == `PESD_OFS_GLOBAL_STATE) begin
      next_dat[0] = global_enable_state & live_sub; // [R3] [R4]
    end else if (hit_sub_en) begin
      next_dat[0] = subblock_enable[en_idx] & live_sub; // [R17]
    end else if (hit_sub_st) begin
      next_dat[0] = subblock_enable_state[st_idx] & live_sub; // [R5]
    end else if ((wb_adr_i == `PESD_OFS_CONTROL) && live_ctl) begin
      next_dat[`PESD_CTL_FREE_BIT] = ctl_free;
      next_dat[`PESD_CTL_SOFT_BIT] = ctl_soft;
      next_dat[`PESD_CTL_PEREN_BIT] = ctl_peren;
    end else if ((wb_adr_i == `PESD_OFS_RUN_STATE) && live_ctl) begin
      next_dat[`PESD_RUN_HALTED_BIT] = halted;
      next_dat[`PESD_RUN_STOPREQ_BIT] = stop_req;
    end
  end

  // One-cycle answer; unmapped addresses still ack with zero data
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Whole-peripheral sequencer gives the global state
  pesd_blkseq #(
    .DRAIN_CYCLES(DRAIN_CYCLES),
    .CNT_W(6)
  ) u_global_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(peripheral_global_enable),
    .sub_reset(),
    .clk_run(),
    .state_on(global_enable_state)
  );

  // Per-subblock sequencers; the global request gates each request,
  // so clearing it walks every running block through its own drain.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SUB; gi = gi + 1) begin : g_sub
      pesd_blkseq #(
        .DRAIN_CYCLES(DRAIN_CYCLES),
        .CNT_W(6)
      ) u_seq (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(peripheral_global_enable
          & subblock_enable[gi]), // [R1] [R18]
        .sub_reset(seq_reset[gi]),
        .clk_run(subblock_clk_en[gi]),
        .state_on(subblock_enable_state[gi])
      );
    end
  endgenerate

  // Sequencer reset flops already include the global term
  assign subblock_reset = seq_reset; // [R1]

  pesd_halt u_halt (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .suspend(susp_sync),
    .free_run(ctl_free),
    .peren(ctl_peren & global_enable_state),
    .rx_pkt_busy(rx_pkt_busy),
    .tx_pkt_busy(tx_pkt_busy),
    .dma_pkt_busy(dma_pkt_busy),
    .rx_buf_full(rx_buf_full),
    .new_pkt_event(new_pkt_event),
    .done_event(done_event),
    .stop_req(stop_req),
    .halted(halted),
    .txn_allow(txn_allow),
    .dma_new_pkt_allow(dma_new_pkt_allow),
    .tx_new_allow(tx_new_allow),
    .rx_retry(rx_retry),
    .cpu_event(cpu_event)
  );
endmodule

// [tb/pesd_checker.sv]
// Concurrent checks on bus, drain sequencing and halt gating
`timescale 1ns/1ns
module pesd_checker #(
  parameter NUM_SUB = 9,
  parameter DRAIN_CYCLES = 32
) (
  // Clock, reset and bus
  input wire logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Activity
  input wire logic rx_pkt_busy, tx_pkt_busy, dma_pkt_busy, rx_buf_full,
  input wire logic new_pkt_event, done_event,
  // Outputs watched
  input wire logic [NUM_SUB-1:0] subblock_reset, subblock_clk_en,
  input wire logic txn_allow, tx_new_allow, rx_retry, cpu_event, halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Cycles block 1 has spent in reset with its clock still on
  logic [5:0] dcnt;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      dcnt <= 6'h00;
    else if (!subblock_reset[1])
      dcnt <= 6'h00;
    else if (subblock_clk_en[1] && dcnt != 6'h3F)
      dcnt <= dcnt + 6'h01;
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_single: assert property (s_req |=> s_ack)
    else $error("request not answered by one ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_clk_restart: assert property ($fell(subblock_reset[1])
    |-> subblock_clk_en[1]) else $error("released without clock");
  a_drain_hold: assert property (subblock_reset[1] && dcnt != 6'h00
    && dcnt < DRAIN_CYCLES |-> subblock_clk_en[1])
    else $error("clock gated before drain count");
  a_gate_late: assert property (dcnt >= DRAIN_CYCLES
    |-> !subblock_clk_en[1]) else $error("clock not gated after drain");
  a_halt_idle: assert property (halted |->
    $past(!rx_pkt_busy && !tx_pkt_busy && !dma_pkt_busy))
    else $error("halted with packet in flight");
  a_halt_block: assert property (halted |->
    !tx_new_allow && !txn_allow)
    else $error("new work allowed while halted");
  a_event_src: assert property (cpu_event
    |-> $past(new_pkt_event || done_event)) else $error("event uncaused");
  a_retry_src: assert property (rx_retry |-> $past(rx_buf_full))
    else $error("retry without full buffers");
endmodule
bind pesd_top pesd_checker #(.NUM_SUB(NUM_SUB), .DRAIN_CYCLES(DRAIN_CYCLES))
  pesd_checker_inst (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .wb_dat_o, .rx_pkt_busy, .tx_pkt_busy, .dma_pkt_busy, .rx_buf_full,
  .new_pkt_event, .done_event, .subblock_reset, .subblock_clk_en,
  .txn_allow, .tx_new_allow, .rx_retry, .cpu_event, .halted);

// [tb/pesd_partner.sv]
// Model of the debug suspend source and subblock packet activity
`timescale 1ns/1ns
module pesd_partner #(
  parameter PKT_LEN = 12
) (
  // Clock, reset and bench commands
  input wire logic sys_clk, sys_rst, pkt_start, susp_cmd,
  input wire logic full_cmd, new_cmd, done_cmd,
  // Toward the design
  output logic debug_suspend_request, rx_buf_full,
  output logic new_pkt_event, done_event,
  output wire logic rx_pkt_busy, tx_pkt_busy, dma_pkt_busy
);
  logic [7:0] left;
  // One packet keeps all paths busy together, the worst case for halting
  assign tx_pkt_busy = left != 8'h00;
  assign rx_pkt_busy = tx_pkt_busy;
  assign dma_pkt_busy = tx_pkt_busy;
  always @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) begin
      left <= 8'h00;
      {debug_suspend_request, rx_buf_full} <= 2'h0;
      {new_pkt_event, done_event} <= 2'h0;
    end else begin
      debug_suspend_request <= susp_cmd;
      rx_buf_full <= full_cmd;
      new_pkt_event <= new_cmd;
      done_event <= done_cmd;
      if (pkt_start)
        left <= PKT_LEN[7:0];
      else if (left != 8'h00)
        left <= left - 8'h01;
    end
endmodule

// [tb/pesd_top_tb.sv]
// Self-checking bench for enable sequencing and halt control
`timescale 1ns/1ns
`include "pesd_map.vh"
module pesd_top_tb;
  localparam DR = 8;
  localparam [15:0] EN = `PESD_OFS_SUB_EN_BASE;
  localparam [15:0] ST = `PESD_OFS_SUB_STATE_BASE;
  localparam [15:0] CT = `PESD_OFS_CONTROL;
  localparam [15:0] GS = `PESD_OFS_GLOBAL_STATE;
  logic sys_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, debug_suspend_request, rx_pkt_busy, tx_pkt_busy;
  logic dma_pkt_busy, rx_buf_full, new_pkt_event, done_event;
  logic susp = 0, full = 0, newe = 0, done = 0, pst = 0;
  logic [8:0] subblock_reset, subblock_clk_en;
  logic txn_allow, dma_new_pkt_allow, tx_new_allow, rx_retry;
  logic cpu_event, halted;
  int fails = 0, num_checks = 0, ncyc = 0, evs = 0, e0;

  always #4 sys_clk = ~sys_clk;

  pesd_top #(.DRAIN_CYCLES(DR)) pesd_top_inst (.sys_clk, .sys_rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .debug_suspend_request, .rx_pkt_busy,
    .tx_pkt_busy, .dma_pkt_busy, .rx_buf_full, .new_pkt_event,
    .done_event, .subblock_reset, .subblock_clk_en, .txn_allow,
    .dma_new_pkt_allow, .tx_new_allow, .rx_retry, .cpu_event, .halted);
  pesd_partner pesd_partner_inst (.sys_clk, .sys_rst, .pkt_start(pst),
    .susp_cmd(susp), .full_cmd(full), .new_cmd(newe), .done_cmd(done),
    .debug_suspend_request, .rx_buf_full, .new_pkt_event, .done_event,
    .rx_pkt_busy, .tx_pkt_busy, .dma_pkt_busy);

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input [15:0] a, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      $display("CHECK FAILED t=%0t no ack", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd(input [15:0] a, input [31:0] e);
    bus(a, 0, 32'h0);
    chk(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    ncyc++;
    if (cpu_event === 1'b1)
      evs <= evs + 1;
    if (ncyc == 5000) begin
      fails++;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_of_test;
    end
  end

  initial begin
    tick(20);
    sys_rst <= 0;
    bus(CT, 1, 32'h4);
    rd(CT, 32'h0);
    rd(GS, 32'h0);
    bus(`PESD_OFS_GLOBAL_EN, 1, 32'h1);
    tick(3);
    rd(GS, 32'h1);
    rd(`PESD_OFS_GLOBAL_EN, 32'h1);
    for (int k = 0; k < 9; k++) bus(EN + 16'(4 * k), 1, 32'h1);
    tick(3);
    for (int k = 0; k < 9; k++) rd(ST + 16'(4 * k), 32'h1);
    chk(subblock_reset, 32'h0);
    chk(subblock_clk_en, 32'h1FF);
    rd(CT, 32'h1);
    rd(16'h0200, 32'h0);
    $display("test enable done");
    bus(EN + 16'hC, 1, 32'h0);
    tick(1);
    chk(subblock_reset[3], 1);
    rd(ST + 16'hC, 32'h1);
    tick(DR + 4);
    chk(subblock_clk_en[3], 0);
    rd(ST + 16'hC, 32'h0);
    bus(EN + 16'h4, 1, 32'h0);
    bus(EN + 16'h4, 1, 32'h1);
    tick(2);
    chk({subblock_reset[1], subblock_clk_en[1]}, 32'h1);
    $display("test drain done");
    bus(CT, 1, 32'h5);
    susp <= 1;
    tick(8);
    chk({halted, txn_allow}, 32'h1);
    pst <= 1;
    tick(1);
    pst <= 0;
    bus(CT, 1, 32'h4);
    tick(3);
    chk(halted, 0);
    chk({tx_new_allow, dma_new_pkt_allow}, 32'h1);
    tick(16);
    chk({halted, tx_new_allow, dma_new_pkt_allow}, 32'h4);
    rd(CT, 32'h4);
    rd(`PESD_OFS_RUN_STATE, 32'h3);
    e0 = evs;
    newe <= 1;
    tick(1);
    newe <= 0;
    tick(4);
    chk(evs, e0);
    done <= 1;
    tick(1);
    done <= 0;
    tick(4);
    chk(evs, e0 + 1);
    full <= 1;
    tick(4);
    chk(rx_retry, 1);
    full <= 0;
    bus(CT, 1, 32'h6);
    tick(4);
    chk(halted, 1);
    susp <= 0;
    tick(8);
    chk(txn_allow, 1);
    bus(CT, 1, 32'h1);
    tick(3);
    chk(txn_allow, 0);
    $display("test halt done");
    // Packets are long finished and DMA idle before the global disable
    tick(DR);
    bus(`PESD_OFS_GLOBAL_EN, 1, 32'h0);
    tick(DR + 6);
    chk(subblock_reset, 32'h1FF);
    chk(subblock_clk_en, 32'h0);
    rd(GS, 32'h0);
    rd(CT, 32'h0);
    rd(`PESD_OFS_RUN_STATE, 32'h0);
    $display("test shutdown done");
    end_of_test;
  end
endmodule
